// File: design/ccr_hold_timer.sv
`default_nettype none
module ccr_hold_timer import ccr_pkg::*; #(
	parameter int unsigned BASE_CYCLES = DELAY_BASE_CYC,
	parameter int CNT_W = CCR_CNT_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Configuration and triggers
	input wire ccr_hold_s cfg,
	input wire logic start,
	input wire logic holdPin,
	// Status
	output logic busy,
	output logic done
);
	typedef enum logic [1:0] {IDLE, WAIT_PIN, WAIT_TIMER} ccr_hstate_e;
	ccr_hstate_e state_r;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] load;
	logic [3:0] code;
	// ----------------------------------------
	// Delay length from code
	// ----------------------------------------
	// Reserved top code behaves as the longest legal one
	always_comb begin
		code = (cfg.holdDelay > HOLD_CODE_MAX) ? HOLD_CODE_MAX : cfg.holdDelay;
		load = '0;
		if (code != 4'h0) begin
			load = CNT_W'(BASE_CYCLES) << (code - 4'h1);
		end
	end
	// ----------------------------------------
	// Wait sequencer
	// ----------------------------------------
	always_ff @(posedge clk) begin
		done <= 1'b0;
		if (reset) begin
			state_r <= IDLE;
			cnt_r <= '0;
		end else begin
			case (state_r)
				IDLE: begin
					if (start && !cfg.holdSrcTimer) begin
						state_r <= WAIT_PIN;
					end else if (start && (load == '0)) begin
						done <= 1'b1;
					end else if (start) begin
						cnt_r <= load - CNT_W'(1);
						state_r <= WAIT_TIMER;
					end
				end
				WAIT_PIN: begin
					if (holdPin) begin
						done <= 1'b1;
						state_r <= IDLE;
					end
				end
				WAIT_TIMER: begin
					if (cnt_r == '0) begin
						done <= 1'b1;
						state_r <= IDLE;
					end else begin
						cnt_r <= cnt_r - CNT_W'(1);
					end
				end
				default: begin
					state_r <= IDLE;
				end
			endcase
		end
	end
	assign busy = (state_r != IDLE);
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_pin_wait;
		@(posedge clk) disable iff (reset)
		(state_r == WAIT_PIN) && !holdPin |=> !done;
	endproperty
	a_pin_wait: assert property (p_pin_wait) else $error("hold ended without pin");
	property p_zero_delay;
		@(posedge clk) disable iff (reset)
		(state_r == IDLE) && start && cfg.holdSrcTimer && (cfg.holdDelay == 4'h0) |=> done;
	endproperty
	a_zero_delay: assert property (p_zero_delay) else $error("zero delay not immediate");
	property p_one_step;
		@(posedge clk) disable iff (reset)
		(state_r == IDLE) && start && cfg.holdSrcTimer && (cfg.holdDelay == 4'h1)
			|=> (cnt_r == CNT_W'(BASE_CYCLES - 1));
	endproperty
	a_one_step: assert property (p_one_step) else $error("first delay step length wrong");
endmodule
`default_nettype wire

// File: design/ccr_regs.sv
`default_nettype none
module ccr_regs import ccr_pkg::*; #(
	parameter int unsigned BASE_CYCLES = DELAY_BASE_CYC,
	parameter int CNT_W = CCR_CNT_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic [7:0] regAddr,
	input wire logic regWriteEn,
	input wire logic [7:0] regWriteData,
	input wire logic regReadEn,
	output logic [7:0] regReadData,
	// Charger state from the analog side
	input wire logic chargeStart,
	input wire logic prechargeMode,
	input wire logic usbDetectDone,
	input wire logic [3:0] usbDetectLimit,
	input wire logic [2:0] tempClass,
	// Power sequencer
	input wire logic seqPowerUp,
	input wire logic seqPowerDown,
	input wire logic holdInputPin,
	// Charger controls
	output logic buckSleepForce,
	output logic chargeSuspend,
	output logic [3:0] usbLimitActive,
	output logic [3:0] adapterLimit,
	output logic [5:0] fastChargeCurrent,
	output logic [1:0] prechargeCurrent,
	output logic [2:0] droopThreshold,
	output logic [4:0] chargeVoltageLimit,
	// Sequence hold and clocks
	output logic slowClockOutEn,
	output logic calClockEn,
	output logic holdActive,
	output logic holdDone
);
	ccr_buck_s buck_r;
	ccr_hold_s hold_r;
	logic [7:0] ilim_r;
	logic [7:0] bchg_r;
	logic [7:0] cvc_r;
	logic holdSeen_r;
	logic timerBusy;
	logic timerDone;
	logic holdStart;
	logic [5:0] effFast;
	logic wrBuck;
	logic wrHold;
	logic wrIlim;
	logic wrBchg;
	logic wrCvc;

	// ----------------------------------------
	// Write decode
	// ----------------------------------------
	assign wrBuck = regWriteEn && (regAddr == ADDR_BUCK);
	assign wrHold = regWriteEn && (regAddr == ADDR_HOLD);
	assign wrIlim = regWriteEn && (regAddr == ADDR_ILIM);
	assign wrBchg = regWriteEn && (regAddr == ADDR_BCHG);
	assign wrCvc = regWriteEn && (regAddr == ADDR_CVC);

	// ----------------------------------------
	// Buck control register
	// ----------------------------------------
	// A write in the charge-start cycle wins, so software intent is kept
	always_ff @(posedge clk) begin
		if (reset) begin
			buck_r <= ccr_buck_s'(RST_BUCK);
		end else if (wrBuck) begin
			buck_r <= ccr_buck_s'(regWriteData);
		end else if (chargeStart) begin
			buck_r.buckSleepForce <= 1'b0;
		end
	end

	// ----------------------------------------
	// Plain configuration registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			hold_r <= ccr_hold_s'(RST_HOLD);
			ilim_r <= RST_ILIM;
			bchg_r <= RST_BCHG;
			cvc_r <= RST_CVC;
		end else begin
			if (wrHold) begin
				hold_r <= ccr_hold_s'(regWriteData);
			end
			if (wrIlim) begin
				ilim_r <= regWriteData;
			end
			if (wrBchg) begin
				bchg_r <= regWriteData;
			end
			if (wrCvc) begin
				cvc_r <= regWriteData;
			end
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	// Registered read data; unmapped offsets read zero
	always_ff @(posedge clk) begin
		if (reset) begin
			regReadData <= RD_UNMAPPED;
		end else if (regReadEn) begin
			case (regAddr)
				ADDR_BUCK: regReadData <= buck_r;
				ADDR_HOLD: regReadData <= hold_r;
				ADDR_ILIM: regReadData <= ilim_r;
				ADDR_BCHG: regReadData <= bchg_r;
				ADDR_CVC: regReadData <= cvc_r;
				default: regReadData <= RD_UNMAPPED;
			endcase
		end
	end

	// ----------------------------------------
	// Thermal current ceiling
	// ----------------------------------------
	ccr_thermal_limit ccr_thermal_limit_inst (
		.enable(buck_r.thermalChargeEn),
		.tempClass(tempClass),
		.progCode(bchg_r[FAST_LSB +: 6]),
		.effCode(effFast)
	);

	// ----------------------------------------
	// Charger outputs
	// ----------------------------------------
	// Suspension covers sleep force and a zero code of the active phase
	always_ff @(posedge clk) begin
		if (reset) begin
			buckSleepForce <= 1'b0;
			chargeSuspend <= 1'b0;
			fastChargeCurrent <= '0;
			prechargeCurrent <= '0;
		end else begin
			buckSleepForce <= buck_r.buckSleepForce;
			fastChargeCurrent <= effFast;
			prechargeCurrent <= bchg_r[PRE_LSB +: 2];
			chargeSuspend <= buck_r.buckSleepForce
				|| (prechargeMode ? (bchg_r[PRE_LSB +: 2] == 2'h0)
				: (effFast == 6'h00));
		end
	end

	// Limits and thresholds pass straight to the analog side, except the USB limit, picked by auto-limit enable and detection
	always_ff @(posedge clk) begin
		if (reset) begin
			usbLimitActive <= '0;
			adapterLimit <= '0;
			droopThreshold <= '0;
			chargeVoltageLimit <= '0;
		end else begin
			if (!buck_r.usbAutoLimitEn) begin
				usbLimitActive <= ilim_r[USB_LIM_LSB +: 4];
			end else if (usbDetectDone) begin
				usbLimitActive <= usbDetectLimit;
			end else begin
				usbLimitActive <= buck_r.buckInputLimit;
			end
			adapterLimit <= ilim_r[ADP_LIM_LSB +: 4];
			droopThreshold <= cvc_r[DROOP_LSB +: 3];
			chargeVoltageLimit <= cvc_r[CV_LSB +: 5];
		end
	end

	// ----------------------------------------
	// Sequence hold
	// ----------------------------------------
	// Power-down holds only when both directions are selected; busy drops new starts
	assign holdStart = !timerBusy && (seqPowerUp || (seqPowerDown && hold_r.holdBothDirs));

	ccr_hold_timer #(
		.BASE_CYCLES(BASE_CYCLES),
		.CNT_W(CNT_W)
	) ccr_hold_timer_inst (
		.clk(clk),
		.reset(reset),
		.cfg(hold_r),
		.start(holdStart),
		.holdPin(holdInputPin),
		.busy(timerBusy),
		.done(timerDone)
	);

	// Hold seen is re-armed at each new hold not started in the done cycle, so the calendar waits again
	always_ff @(posedge clk) begin
		if (reset) begin
			holdSeen_r <= 1'b0;
		end else if (timerDone) begin
			holdSeen_r <= 1'b1;
		end else if (holdStart) begin
			holdSeen_r <= 1'b0;
		end
	end

	// Hold and clock outputs
	always_ff @(posedge clk) begin
		if (reset) begin
			holdActive <= 1'b0;
			holdDone <= 1'b0;
			slowClockOutEn <= 1'b0;
			calClockEn <= 1'b1;
		end else begin
			holdActive <= timerBusy;
			holdDone <= timerDone;
			slowClockOutEn <= hold_r.slowClockOutEn;
			calClockEn <= !hold_r.calGate || holdSeen_r;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_sleep_clear;
		@(posedge clk) disable iff (reset)
		chargeStart && !wrBuck |=> ##1 !buckSleepForce;
	endproperty
	a_sleep_clear: assert property (p_sleep_clear) else $error("sleep force kept");
	property p_sleep_susp;
		@(posedge clk) disable iff (reset)
		buck_r.buckSleepForce |=> chargeSuspend;
	endproperty
	a_sleep_susp: assert property (p_sleep_susp) else $error("sleep did not suspend");
	property p_usb_fixed;
		@(posedge clk) disable iff (reset)
		!buck_r.usbAutoLimitEn |=> (usbLimitActive == $past(ilim_r[USB_LIM_LSB +: 4]));
	endproperty
	a_usb_fixed: assert property (p_usb_fixed) else $error("fixed USB limit not used");
	property p_therm_off;
		@(posedge clk) disable iff (reset)
		!buck_r.thermalChargeEn |=> (fastChargeCurrent == $past(bchg_r[FAST_LSB +: 6]));
	endproperty
	a_therm_off: assert property (p_therm_off) else $error("current cut while disabled");
	property p_therm_hot;
		@(posedge clk) disable iff (reset)
		buck_r.thermalChargeEn && (tempClass == 3'h6) |=> (fastChargeCurrent == 6'h00);
	endproperty
	a_therm_hot: assert property (p_therm_hot) else $error("hot class not suspended");
	property p_fast_zero;
		@(posedge clk) disable iff (reset)
		!prechargeMode && (effFast == 6'h00) |=> chargeSuspend;
	endproperty
	a_fast_zero: assert property (p_fast_zero) else $error("zero fast code not suspended");
	property p_pre_zero;
		@(posedge clk) disable iff (reset)
		prechargeMode && (bchg_r[PRE_LSB +: 2] == 2'h0) |=> chargeSuspend;
	endproperty
	a_pre_zero: assert property (p_pre_zero) else $error("zero pre code not suspended");
	property p_down_skip;
		@(posedge clk) disable iff (reset)
		seqPowerDown && !seqPowerUp && !hold_r.holdBothDirs && !timerBusy |=> !timerBusy;
	endproperty
	a_down_skip: assert property (p_down_skip) else $error("power-down hold not wanted");
	property p_cal_gate;
		@(posedge clk) disable iff (reset)
		hold_r.calGate && !holdSeen_r && $stable(hold_r) |=> !calClockEn;
	endproperty
	a_cal_gate: assert property (p_cal_gate) else $error("calendar clock not gated");
	property p_slow_clk;
		@(posedge clk) disable iff (reset)
		wrHold |=> ##1 (slowClockOutEn == $past(regWriteData[4], 2));
	endproperty
	a_slow_clk: assert property (p_slow_clk) else $error("slow clock enable wrong");
	sequence s_write_ilim;
		wrIlim ##1 (regReadEn && (regAddr == ADDR_ILIM) && !regWriteEn);
	endsequence
	property p_readback;
		@(posedge clk) disable iff (reset)
		s_write_ilim |=> (regReadData == $past(regWriteData, 2));
	endproperty
	a_readback: assert property (p_readback) else $error("readback mismatch");
	property p_droop;
		@(posedge clk) disable iff (reset)
		wrCvc |=> ##1 (droopThreshold == $past(regWriteData[2:0], 2));
	endproperty
	a_droop: assert property (p_droop) else $error("droop code not passed");
endmodule
`default_nettype wire

// File: design/ccr_thermal_limit.sv
`default_nettype none
module ccr_thermal_limit import ccr_pkg::*; (
	// Control
	input wire logic enable,
	input wire logic [2:0] tempClass,
	// Current codes
	input wire logic [5:0] progCode,
	output logic [5:0] effCode
);
	// ----------------------------------------
	// Ceiling selection
	// ----------------------------------------
	logic [5:0] ceiling;
	// Take the lower of programmed code and class ceiling
	always_comb begin
		ceiling = THERM_LIMIT[tempClass];
		effCode = progCode;
		if (enable && (ceiling < progCode)) begin
			effCode = ceiling;
		end
	end
endmodule
`default_nettype wire

// File: include/ccr_pkg.sv
`default_nettype none
package ccr_pkg;
	// ----------------------------------------
	// Register offsets and reset values
	// ----------------------------------------
	localparam logic [7:0] ADDR_BUCK = 8'h3e;
	localparam logic [7:0] ADDR_HOLD = 8'h3f;
	localparam logic [7:0] ADDR_ILIM = 8'h40;
	localparam logic [7:0] ADDR_BCHG = 8'h41;
	localparam logic [7:0] ADDR_CVC = 8'h42;
	localparam logic [7:0] RST_BUCK = 8'h00;
	localparam logic [7:0] RST_HOLD = 8'h00;
	localparam logic [7:0] RST_ILIM = 8'h00;
	localparam logic [7:0] RST_BCHG = 8'h00;
	localparam logic [7:0] RST_CVC = 8'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int USB_LIM_LSB = 0;
	localparam int ADP_LIM_LSB = 4;
	localparam int FAST_LSB = 0;
	localparam int PRE_LSB = 6;
	localparam int DROOP_LSB = 0;
	localparam int CV_LSB = 3;
	// ----------------------------------------
	// Hold delay timing
	// ----------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned DELAY_BASE_NS = 540000;
	localparam int unsigned DELAY_BASE_CYC = DELAY_BASE_NS / CLK_PERIOD_NS;
	localparam logic [3:0] HOLD_CODE_MAX = 4'he;
	localparam int CCR_CNT_W = 28;
	// ----------------------------------------
	// Thermal current ceilings per class
	// ----------------------------------------
	localparam logic [5:0] THERM_LIMIT [0:7] = '{6'h3f, 6'h37, 6'h2d, 6'h23, 6'h19, 6'h0f,
		6'h00, 6'h00};
	// ----------------------------------------
	// Register layouts
	// ----------------------------------------
	typedef struct packed {
		logic thermalChargeEn;
		logic usbAutoLimitEn;
		logic buckSleepForce;
		logic chargerEnable;
		logic [3:0] buckInputLimit;
	} ccr_buck_s;
	typedef struct packed {
		logic holdBothDirs;
		logic calGate;
		logic holdSrcTimer;
		logic slowClockOutEn;
		logic [3:0] holdDelay;
	} ccr_hold_s;
endpackage
`default_nettype wire

// File: tb/ccr_regs_tb.sv
`default_nettype none
module ccr_regs_tb import ccr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic clk, reset, regWriteEn, regReadEn, chargeStart, prechargeMode, usbDetectDone;
	logic seqPowerUp, seqPowerDown, holdInputPin;
	logic [7:0] regAddr, regWriteData, regReadData;
	logic [3:0] usbDetectLimit, usbLimitActive, adapterLimit;
	logic [2:0] tempClass, droopThreshold;
	logic buckSleepForce, chargeSuspend, slowClockOutEn, calClockEn, holdActive, holdDone;
	logic [5:0] fastChargeCurrent;
	logic [1:0] prechargeCurrent;
	logic [4:0] chargeVoltageLimit;
	int nFail = 0;
	int nCompared = 0;
	int cycles = 0;
	// Small base count keeps the longest hold short in simulation
	localparam int TB_BASE = 4;
	ccr_regs #(.BASE_CYCLES(TB_BASE), .CNT_W(CCR_CNT_W)) ccr_regs_inst (
		.clk(clk), .reset(reset),
		.regAddr(regAddr), .regWriteEn(regWriteEn), .regWriteData(regWriteData),
		.regReadEn(regReadEn), .regReadData(regReadData),
		.chargeStart(chargeStart), .prechargeMode(prechargeMode),
		.usbDetectDone(usbDetectDone), .usbDetectLimit(usbDetectLimit), .tempClass(tempClass),
		.seqPowerUp(seqPowerUp), .seqPowerDown(seqPowerDown), .holdInputPin(holdInputPin),
		.buckSleepForce(buckSleepForce), .chargeSuspend(chargeSuspend),
		.usbLimitActive(usbLimitActive), .adapterLimit(adapterLimit),
		.fastChargeCurrent(fastChargeCurrent), .prechargeCurrent(prechargeCurrent),
		.droopThreshold(droopThreshold), .chargeVoltageLimit(chargeVoltageLimit),
		.slowClockOutEn(slowClockOutEn), .calClockEn(calClockEn),
		.holdActive(holdActive), .holdDone(holdDone)
	);
	// ----------------------------------------
	// Clock and hang guard
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			nFail++;
			endOfTest();
		end
	end
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic endOfTest();
		if (nFail == 0 && nCompared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			nFail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Ends one extra edge late so derived outputs have settled
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		regAddr = a;
		regWriteData = d;
		regWriteEn = 1'b1;
		@(negedge clk);
		regWriteEn = 1'b0;
		@(negedge clk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		regAddr = a;
		regReadEn = 1'b1;
		@(negedge clk);
		regReadEn = 1'b0;
		chk(regReadData, exp);
	endtask
	task automatic settle();
		repeat (3) @(negedge clk);
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rdchk(ADDR_BUCK, RST_BUCK);
		rdchk(ADDR_HOLD, RST_HOLD);
		rdchk(ADDR_ILIM, RST_ILIM);
		rdchk(ADDR_BCHG, RST_BCHG);
		rdchk(ADDR_CVC, RST_CVC);
		chk(calClockEn, 1'b1);
		chk(slowClockOutEn, 1'b0);
		wr(8'h43, 8'hff);
		rdchk(8'h43, RD_UNMAPPED);
		rdchk(ADDR_CVC, 8'h00);
	endtask
	task automatic t_fields();
		wr(ADDR_ILIM, 8'h5a);
		chk(adapterLimit, 4'h5);
		chk(usbLimitActive, 4'ha);
		wr(ADDR_BCHG, 8'h95);
		chk(fastChargeCurrent, 6'h15);
		chk(prechargeCurrent, 2'h2);
		chk(chargeSuspend, 1'b0);
		wr(ADDR_CVC, 8'ha6);
		chk(droopThreshold, 3'h6);
		chk(chargeVoltageLimit, 5'h14);
		wr(ADDR_HOLD, 8'h10);
		chk(slowClockOutEn, 1'b1);
		rdchk(ADDR_ILIM, 8'h5a);
		rdchk(ADDR_BCHG, 8'h95);
		rdchk(ADDR_CVC, 8'ha6);
		rdchk(ADDR_HOLD, 8'h10);
		prechargeMode = 1'b1;
		wr(ADDR_BCHG, 8'h15);
		chk(chargeSuspend, 1'b1);
		prechargeMode = 1'b0;
		settle();
		chk(chargeSuspend, 1'b0);
		wr(ADDR_BCHG, 8'h80);
		chk(chargeSuspend, 1'b1);
		wr(ADDR_HOLD, 8'h00);
		chk(slowClockOutEn, 1'b0);
	endtask
	// Write then read at the very next edge, no idle cycle between
	task automatic t_b2b();
		@(negedge clk);
		regAddr = ADDR_ILIM;
		regWriteData = 8'h3c;
		regWriteEn = 1'b1;
		@(negedge clk);
		regWriteEn = 1'b0;
		regReadEn = 1'b1;
		@(negedge clk);
		regReadEn = 1'b0;
		chk(regReadData, 8'h3c);
		chk(adapterLimit, 4'h3);
		wr(ADDR_ILIM, 8'h5a);
	endtask
	task automatic t_sleep();
		wr(ADDR_BCHG, 8'h15);
		wr(ADDR_BUCK, 8'h20);
		chk(buckSleepForce, 1'b1);
		chk(chargeSuspend, 1'b1);
		rdchk(ADDR_BUCK, 8'h20);
		@(negedge clk);
		chargeStart = 1'b1;
		@(negedge clk);
		chargeStart = 1'b0;
		settle();
		chk(buckSleepForce, 1'b0);
		chk(chargeSuspend, 1'b0);
		rdchk(ADDR_BUCK, 8'h00);
	endtask
	task automatic t_usb();
		wr(ADDR_BUCK, 8'h47);
		chk(usbLimitActive, 4'h7);
		usbDetectLimit = 4'hc;
		usbDetectDone = 1'b1;
		settle();
		chk(usbLimitActive, 4'hc);
		wr(ADDR_BUCK, 8'h07);
		chk(usbLimitActive, 4'ha);
		usbDetectDone = 1'b0;
	endtask
	// Ceiling per junction class when thermal reduction is on
	task automatic t_thermal();
		logic [5:0] ceil [0:7];
		ceil = '{6'h3f, 6'h37, 6'h2d, 6'h23, 6'h19, 6'h0f, 6'h00, 6'h00};
		wr(ADDR_BCHG, 8'h3f);
		tempClass = 3'h5;
		settle();
		chk(fastChargeCurrent, 6'h3f);
		wr(ADDR_BUCK, 8'h80);
		for (int c = 0; c < 8; c++) begin
			tempClass = 3'(c);
			settle();
			chk(fastChargeCurrent, ceil[c]);
		end
		chk(chargeSuspend, 1'b1);
		tempClass = 3'h3;
		wr(ADDR_BCHG, 8'h10);
		chk(fastChargeCurrent, 6'h10);
		rdchk(ADDR_BCHG, 8'h10);
		tempClass = 3'h0;
		wr(ADDR_BUCK, 8'h00);
	endtask
	// Edges from the start edge to the done pulse: delay count plus one output stage
	task automatic hold_run(input logic [3:0] code);
		int n;
		int exp;
		exp = (code == 4'h0) ? 1 : (TB_BASE << (code - 1)) + 1;
		wr(ADDR_HOLD, {4'h2, code});
		@(negedge clk);
		seqPowerUp = 1'b1;
		@(negedge clk);
		seqPowerUp = 1'b0;
		n = 0;
		chk(calClockEn, 1'b1);
		while (holdDone !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		chk(n, exp);
		settle();
	endtask
	task automatic t_pin();
		int n;
		wr(ADDR_HOLD, 8'h40);
		@(negedge clk);
		seqPowerUp = 1'b1;
		@(negedge clk);
		seqPowerUp = 1'b0;
		repeat (8) @(negedge clk);
		chk(holdActive, 1'b1);
		chk(holdDone, 1'b0);
		chk(calClockEn, 1'b0);
		holdInputPin = 1'b1;
		n = 0;
		while (holdDone !== 1'b1 && n < 6) begin
			@(negedge clk);
			n++;
		end
		chk(holdDone, 1'b1);
		holdInputPin = 1'b0;
		settle();
		chk(calClockEn, 1'b1);
		chk(holdActive, 1'b0);
	endtask
	// Power-down start only counts when the direction bit is set
	task automatic dir_run(input logic [7:0] cfg, input logic exp);
		logic seen;
		seen = 1'b0;
		wr(ADDR_HOLD, cfg);
		@(negedge clk);
		seqPowerDown = 1'b1;
		@(negedge clk);
		seqPowerDown = 1'b0;
		repeat (6) begin
			seen = seen | (holdActive === 1'b1) | (holdDone === 1'b1);
			@(negedge clk);
		end
		chk(seen, exp);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{regWriteEn, regReadEn, chargeStart, prechargeMode, usbDetectDone} = 5'h00;
		{seqPowerUp, seqPowerDown, holdInputPin} = 3'h0;
		regAddr = 8'h00;
		regWriteData = 8'h00;
		usbDetectLimit = 4'h0;
		tempClass = 3'h0;
		reset = 1'b1;
		repeat (2) @(negedge clk);
		reset = 1'b0;
		t_reset();
		t_fields();
		t_b2b();
		t_sleep();
		t_usb();
		t_thermal();
		for (int k = 0; k < 4; k++) hold_run(4'(k));
		t_pin();
		dir_run(8'h21, 1'b0);
		dir_run(8'ha1, 1'b1);
		endOfTest();
	end
endmodule
`default_nettype wire
